// [verilog/vout_ctrl_slave.v]
// serial slave, registers and power sequencing for the output control block
`timescale 1ns/1ps
`default_nettype none
`include "vout_ctrl_defines.vh"
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - over 6.5V: retry regulates, else latch if input overvoltage too
// - absolute overvoltage armed once supply, enable up
// - shut down over 160C, resume below 140C
// - temperature flags in status bits 1, 2
// - start needs all supplies; reference before regulator
// - shutdown blocks signal path, then pulls down
// - divider soft start first, then bus accepted
// - no traffic keeps divider loop running
// - divider loop reference fixed at 0.6V
// - serial loop ramps dac at selected slew
// - strap picks one of four addresses
// - address byte: seven bits plus direction
// - sda changes only while scl low
// - detect start and stop conditions
// - eight bits then acknowledge clock
// - acknowledge address and each written byte while addressed; read bytes acked by master
// - data applied at last bit falling edge
// - loop select resets to divider feedback
// - arm bit auto-clears after reference set
module vout_ctrl_slave (
  input wire core_clk,
  input wire rst,
  input wire sclIn,
  input wire sdaIn,
  output reg sdaOut,
  output reg sdaOe,
  input wire [1:0] addressSelectPin,
  input wire vinOk,
  input wire vccOk,
  input wire enableIn,
  input wire outAbove6v5,
  input wire inputOvp,
  input wire tempAbove160,
  input wire tempBelow140,
  input wire tempWarn,
  input wire ocpLatch,
  input wire softStartDone,
  input wire [7:0] outCurrent,
  input wire [7:0] outVoltage,
  output reg refEnable,
  output reg regulatorEnable,
  output reg signalPathBlock,
  output reg errorAmpOutputPulldown,
  output reg railPulldown,
  output reg feedbackInputSelect,
  output reg [6:0] refCode,
  output reg dynamicRegulation,
  output reg absoluteOvervoltageArmed,
  output reg ovLatched,
  output reg thermalShutdown,
  output reg [7:0] ctrl1,
  output reg [7:0] ctrl2
);
  parameter [7:0] ID_VALUE = 8'h5A; // arbitrary identity value
  localparam S_IDLE = 3'h0;
  localparam S_ADDR = 3'h1;
  localparam S_AACK = 3'h2;
  localparam S_WRITE = 3'h3;
  localparam S_WACK = 3'h4;
  localparam S_READ = 3'h5;
  localparam S_RACK = 3'h6;
  localparam S_IGNORE = 3'h7;
  localparam P_OFF = 2'h0;
  localparam P_REF = 2'h1;
  localparam P_ON = 2'h2;
  localparam P_DOWN = 2'h3;
  localparam [31:0] SEQ_WIDE = `SEQ_STEP_CYC;
  localparam [7:0] SEQ_STEP = SEQ_WIDE[7:0];
  //////////////////////////////////////////////////////////////////////////////
  wire scl;
  wire sda;
  wire vinS;
  wire vccS;
  wire enS;
  wire ovS;
  wire inOvS;
  wire hotS;
  wire coolS;
  wire warnS;
  wire ocpS;
  wire ssS;
  wire [1:0] addrS;
  sync2 uScl (.clk(core_clk), .d(sclIn), .q(scl));
  sync2 uSda (.clk(core_clk), .d(sdaIn), .q(sda));
  sync2 uVin (.clk(core_clk), .d(vinOk), .q(vinS));
  sync2 uVcc (.clk(core_clk), .d(vccOk), .q(vccS));
  sync2 uEn (.clk(core_clk), .d(enableIn), .q(enS));
  sync2 uOv (.clk(core_clk), .d(outAbove6v5), .q(ovS));
  sync2 uInOv (.clk(core_clk), .d(inputOvp), .q(inOvS));
  sync2 uHot (.clk(core_clk), .d(tempAbove160), .q(hotS));
  sync2 uCool (.clk(core_clk), .d(tempBelow140), .q(coolS));
  sync2 uWarn (.clk(core_clk), .d(tempWarn), .q(warnS));
  sync2 uOcp (.clk(core_clk), .d(ocpLatch), .q(ocpS));
  sync2 uSs (.clk(core_clk), .d(softStartDone), .q(ssS));
  sync2 uA0 (.clk(core_clk), .d(addressSelectPin[0]), .q(addrS[0]));
  sync2 uA1 (.clk(core_clk), .d(addressSelectPin[1]), .q(addrS[1]));
  //////////////////////////////////////////////////////////////////////////////
  // power sequencing
  reg [1:0] pState;
  reg [7:0] seqCnt;
  wire supplyOk = vinS & vccS & enS;
  wire shutReq = ~supplyOk | thermalShutdown | ovLatched | ocpS;
  always @(posedge core_clk) begin
    if (rst) begin
      thermalShutdown <= 1'b0;
      absoluteOvervoltageArmed <= 1'b0;
      ovLatched <= 1'b0;
      dynamicRegulation <= 1'b0;
    end else begin
      if (hotS) thermalShutdown <= 1'b1;
      else if (coolS) thermalShutdown <= 1'b0;
      absoluteOvervoltageArmed <= vinS & enS;
      dynamicRegulation <= absoluteOvervoltageArmed & ovS & ctrl1[`RETRY_BIT];
      if (absoluteOvervoltageArmed & ovS & inOvS & ~ctrl1[`RETRY_BIT]) ovLatched <= 1'b1;
      else if (~enS | ~vinS) ovLatched <= 1'b0;
    end
  end
  always @(posedge core_clk) begin
    if (rst) begin
      pState <= P_OFF;
      seqCnt <= 8'h00;
      refEnable <= 1'b0;
      regulatorEnable <= 1'b0;
      signalPathBlock <= 1'b1;
      errorAmpOutputPulldown <= 1'b1;
      railPulldown <= 1'b1;
    end else begin
      case (pState)
        P_OFF: begin
          seqCnt <= 8'h00;
          if (~shutReq) begin
            refEnable <= 1'b1;
            pState <= P_REF;
          end
        end
        P_REF: begin
          // reference gets time to settle before the regulator
          if (shutReq) pState <= P_DOWN;
          else if (seqCnt == SEQ_STEP) begin
            regulatorEnable <= 1'b1;
            signalPathBlock <= 1'b0;
            errorAmpOutputPulldown <= 1'b0;
            railPulldown <= 1'b0;
            pState <= P_ON;
          end else seqCnt <= seqCnt + 8'h01;
        end
        P_ON: begin
          if (shutReq) begin
            signalPathBlock <= 1'b1;
            seqCnt <= 8'h00;
            pState <= P_DOWN;
          end
        end
        P_DOWN: begin
          signalPathBlock <= 1'b1;
          if (seqCnt == SEQ_STEP) begin
            errorAmpOutputPulldown <= 1'b1;
            railPulldown <= 1'b1;
            regulatorEnable <= 1'b0;
            refEnable <= 1'b0;
            pState <= P_OFF;
          end else seqCnt <= seqCnt + 8'h01;
        end
        default: pState <= P_OFF;
      endcase
    end
  end
  wire running = (pState == P_ON);
  wire busReady = running & ssS;
  //////////////////////////////////////////////////////////////////////////////
  // serial slave
  reg sclD;
  reg sdaD;
  wire sclRise = scl & ~sclD;
  wire sclFall = ~scl & sclD;
  wire startCond = scl & sclD & sdaD & ~sda;
  wire stopCond = scl & sclD & ~sdaD & sda;
  reg [2:0] st;
  reg [2:0] bitCnt;
  reg [7:0] shift;
  reg [7:0] regPtr;
  reg ptrDone;
  reg [7:0] vsel;
  reg [7:0] txByte;
  reg lastBit;
  reg rampStart;
  wire [6:0] slaveAddr = `SLAVE_ADDR_BASE | {4'h0, addrS, 1'b0};
  reg [7:0] readMux;
  always @* begin
    case (regPtr)
      `REG_VSEL: readMux = vsel;
      `REG_CTRL1: readMux = ctrl1;
      `REG_CTRL2: readMux = ctrl2;
      `REG_IOUT: readMux = outCurrent;
      `REG_VOUT: readMux = outVoltage;
      `REG_ID: readMux = ID_VALUE;
      `REG_STATUS: readMux = {4'h0, ocpS, warnS, thermalShutdown, ssS};
      default: readMux = 8'h00;
    endcase
  end
  always @(posedge core_clk) begin
    if (rst) begin
      sclD <= 1'b1;
      sdaD <= 1'b1;
      st <= S_IDLE;
      bitCnt <= 3'h0;
      shift <= 8'h00;
      regPtr <= 8'h00;
      ptrDone <= 1'b0;
      vsel <= `VSEL_RESET;
      ctrl1 <= `CTRL1_RESET;
      ctrl2 <= `CTRL2_RESET;
      sdaOut <= 1'b0;
      sdaOe <= 1'b0;
      txByte <= 8'h00;
      lastBit <= 1'b0;
      rampStart <= 1'b0;
    end else begin
      sclD <= scl;
      sdaD <= sda;
      rampStart <= 1'b0;
      if (~busReady) begin
        st <= S_IDLE;
        sdaOe <= 1'b0;
      end else if (startCond) begin
        st <= S_ADDR;
        bitCnt <= 3'h0;
        ptrDone <= 1'b0;
        sdaOe <= 1'b0;
      end else if (stopCond) begin
        st <= S_IDLE;
        sdaOe <= 1'b0;
      end else begin
        case (st)
          S_IDLE: sdaOe <= 1'b0;
          S_ADDR, S_WRITE: begin
            if (sclRise) begin
              shift <= {shift[6:0], sda};
              bitCnt <= bitCnt + 3'h1;
              lastBit <= (bitCnt == 3'h7);
            end
            if (sclFall & lastBit) begin
              lastBit <= 1'b0;
              if (st == S_ADDR) begin
                if (shift[7:1] == slaveAddr) begin
                  sdaOut <= 1'b0;
                  sdaOe <= 1'b1;
                  st <= S_AACK;
                end else st <= S_IGNORE;
              end else begin
                sdaOut <= 1'b0;
                sdaOe <= 1'b1;
                st <= S_WACK;
                if (~ptrDone) begin
                  regPtr <= shift;
                  ptrDone <= 1'b1;
                end else begin
                  case (regPtr)
                    `REG_VSEL: begin
                      vsel <= shift;
                      if (~shift[`LOOP_SEL_BIT] & ctrl1[`ARM_BIT]) begin
                        rampStart <= 1'b1;
                        ctrl1[`ARM_BIT] <= 1'b0;
                      end
                    end
                    `REG_CTRL1: ctrl1 <= shift;
                    `REG_CTRL2: ctrl2 <= shift;
                    default: ;
                  endcase
                end
              end
            end
          end
          S_AACK: begin
            if (sclFall) begin
              bitCnt <= 3'h0;
              if (shift[0]) begin
                txByte <= {readMux[6:0], 1'b0};
                sdaOut <= readMux[7];
                sdaOe <= ~readMux[7];
                st <= S_READ;
              end else begin
                sdaOe <= 1'b0;
                st <= S_WRITE;
              end
            end
          end
          S_WACK: begin
            if (sclFall) begin
              sdaOe <= 1'b0;
              bitCnt <= 3'h0;
              st <= S_WRITE;
            end
          end
          S_READ: begin
            if (sclFall) begin
              bitCnt <= bitCnt + 3'h1;
              if (bitCnt == 3'h7) begin
                sdaOe <= 1'b0;
                st <= S_RACK;
              end else begin
                // open drain: drive only zeros
                sdaOut <= 1'b0;
                sdaOe <= ~txByte[7];
                txByte <= {txByte[6:0], 1'b0};
              end
            end
          end
          S_RACK: begin
            if (sclRise) begin
              if (sda) st <= S_IGNORE;
            end else if (sclFall) begin
              bitCnt <= 3'h0;
              txByte <= {readMux[6:0], 1'b0};
              sdaOut <= 1'b0;
              sdaOe <= ~readMux[7];
              st <= S_READ;
            end
          end
          S_IGNORE: sdaOe <= 1'b0;
          default: st <= S_IDLE;
        endcase
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // reference selection; loop switch carries no slew, master stages it
  wire [6:0] dacCode;
  reg loopWasDivider;
  ref_ramp uRamp (
    .core_clk(core_clk),
    .rst(rst),
    .start(rampStart),
    .target(vsel[6:0]),
    .slewSel(ctrl1[`SLEW_MSB:`SLEW_LSB]),
    .loadValue(vsel[6:0]),
    .load(loopWasDivider & ~vsel[`LOOP_SEL_BIT]),
    .code(dacCode),
    .busy()
  );
  always @(posedge core_clk) begin
    if (rst) begin
      loopWasDivider <= 1'b1;
      feedbackInputSelect <= 1'b1;
      refCode <= `FIXED_REF_CODE;
    end else begin
      loopWasDivider <= vsel[`LOOP_SEL_BIT];
      feedbackInputSelect <= vsel[`LOOP_SEL_BIT];
      if (vsel[`LOOP_SEL_BIT]) refCode <= `FIXED_REF_CODE;
      else refCode <= dacCode;
    end
  end
endmodule // vout_ctrl_slave
`default_nettype wire

// [verilog/vout_ctrl_defines.vh]
// constants for the output control serial slave
`ifndef VOUT_CTRL_DEFINES_VH
`define VOUT_CTRL_DEFINES_VH
`define REG_VSEL 8'h00
`define REG_CTRL1 8'h01
`define REG_CTRL2 8'h02
`define REG_IOUT 8'h03
`define REG_VOUT 8'h04
`define REG_ID 8'h05
`define REG_STATUS 8'h06
`define VSEL_RESET 8'h9E
`define CTRL1_RESET 8'h80
`define CTRL2_RESET 8'h00
`define LOOP_SEL_BIT 7
`define ARM_BIT 6
`define SLEW_MSB 5
`define SLEW_LSB 3
`define RETRY_BIT 4
`define FIXED_REF_CODE 7'h00
`define SLAVE_ADDR_BASE 7'h60
`define SLEW_UNIT_NS 1000
`define CLK_PERIOD_NS 10
`define SLEW_UNIT_CYC (`SLEW_UNIT_NS / `CLK_PERIOD_NS)
`define SEQ_STEP_NS 100
`define SEQ_STEP_CYC (`SEQ_STEP_NS / `CLK_PERIOD_NS)
`endif

// [verilog/sync2.v]
// two-flop synchroniser for one level
`timescale 1ns/1ps
`default_nettype none
module sync2 (
  input wire clk,
  input wire d,
  output reg q
);
  reg meta;
  always @(posedge clk) begin
    meta <= d;
    q <= meta;
  end
endmodule // sync2
`default_nettype wire

// [verilog/ref_ramp.v]
// reference dac ramp with selectable slew step interval
`timescale 1ns/1ps
`default_nettype none
`include "vout_ctrl_defines.vh"
module ref_ramp (
  input wire core_clk,
  input wire rst,
  input wire start,
  input wire [6:0] target,
  input wire [2:0] slewSel,
  input wire [6:0] loadValue,
  input wire load,
  output reg [6:0] code,
  output reg busy
);
  reg [15:0] tick;
  wire [15:0] interval;
  reg [6:0] goal;
  localparam [31:0] UNIT_WIDE = `SLEW_UNIT_CYC;
  localparam [15:0] UNIT = UNIT_WIDE[15:0];
  // slower codes double the dwell per step
  assign interval = UNIT << slewSel;
  always @(posedge core_clk) begin
    if (rst) begin
      code <= 7'h00;
      goal <= 7'h00;
      busy <= 1'b0;
      tick <= 16'h0000;
    end else if (load) begin
      code <= loadValue;
      goal <= loadValue;
      busy <= 1'b0;
      tick <= 16'h0000;
    end else if (start) begin
      goal <= target;
      busy <= (target != code);
      tick <= 16'h0000;
    end else if (busy) begin
      if (tick + 16'h0001 >= interval) begin
        tick <= 16'h0000;
        if (goal > code) code <= code + 7'h01;
        else if (goal < code) code <= code - 7'h01;
        busy <= ((goal > code) ? (goal != code + 7'h01) : (goal != code - 7'h01));
      end else begin
        tick <= tick + 16'h0001;
      end
    end
  end
endmodule // ref_ramp
`default_nettype wire

// [verification/vout_ctrl_slave_props.sv]
// assertion checker for the output control serial slave
`timescale 1ns/1ps
`default_nettype none
`include "vout_ctrl_defines.vh"
module vout_ctrl_slave_props (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sclIn,
  input wire logic vinOk,
  input wire logic enableIn,
  input wire logic outAbove6v5,
  input wire logic inputOvp,
  input wire logic tempAbove160,
  input wire logic sdaOe,
  input wire logic refEnable,
  input wire logic regulatorEnable,
  input wire logic signalPathBlock,
  input wire logic railPulldown,
  input wire logic feedbackInputSelect,
  input wire logic [6:0] refCode,
  input wire logic dynamicRegulation,
  input wire logic absoluteOvervoltageArmed,
  input wire logic ovLatched,
  input wire logic thermalShutdown,
  input wire logic [7:0] ctrl1
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  property p_retryRegulates;
    $rose(dynamicRegulation) |-> $past(ctrl1[`RETRY_BIT]) && $past(outAbove6v5, 3);
  endproperty
  a_retryRegulates: assert property (p_retryRegulates)
    else $error("dynamic regulation without retry and overvoltage");
  property p_latchNeedsBoth;
    $rose(ovLatched) |-> $past(inputOvp, 3) && $past(outAbove6v5, 3) && !$past(ctrl1[`RETRY_BIT]);
  endproperty
  a_latchNeedsBoth: assert property (p_latchNeedsBoth)
    else $error("latch without both overvoltage conditions");
  property p_armNeedsSupply;
    $rose(absoluteOvervoltageArmed) |-> $past(vinOk, 3) && $past(enableIn, 3);
  endproperty
  a_armNeedsSupply: assert property (p_armNeedsSupply)
    else $error("overvoltage armed without supply and enable");
  property p_tsdEntry;
    $rose(thermalShutdown) |-> $past(tempAbove160, 3);
  endproperty
  a_tsdEntry: assert property (p_tsdEntry)
    else $error("thermal shutdown without over temperature");
  // a slack of five cycles keeps this independent of the exact step count
  property p_refBeforeReg;
    $rose(regulatorEnable) |-> $past(refEnable, 5);
  endproperty
  a_refBeforeReg: assert property (p_refBeforeReg)
    else $error("regulator enabled before reference");
  property p_blockBeforePull;
    $rose(railPulldown) |-> $past(signalPathBlock, 5);
  endproperty
  a_blockBeforePull: assert property (p_blockBeforePull)
    else $error("rail pulled down before signal path blocked");
  property p_fixedRef;
    feedbackInputSelect && $past(feedbackInputSelect, 2) |-> refCode == `FIXED_REF_CODE;
  endproperty
  a_fixedRef: assert property (p_fixedRef)
    else $error("reference moved in divider loop");
  property p_sdaLowPhase;
    $changed(sdaOe) |-> !sclIn && !$past(sclIn);
  endproperty
  a_sdaLowPhase: assert property (p_sdaLowPhase)
    else $error("data line changed while clock high");
endmodule // vout_ctrl_slave_props
bind vout_ctrl_slave vout_ctrl_slave_props u_vout_ctrl_slave_props (
  .core_clk, .rst, .sclIn, .vinOk, .enableIn, .outAbove6v5, .inputOvp, .tempAbove160,
  .sdaOe, .refEnable, .regulatorEnable, .signalPathBlock, .railPulldown,
  .feedbackInputSelect, .refCode, .dynamicRegulation, .absoluteOvervoltageArmed,
  .ovLatched, .thermalShutdown, .ctrl1
);
`default_nettype wire

// [verification/bus_master.sv]
// two-wire bus master model driving the slave's bus pins
`timescale 1ns/1ps
`default_nettype none
module bus_master (
  output logic scl,
  output logic sdaLow,
  input wire logic sdaLine
);
  // clock idles high between frames, data released
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic bitx(input logic o, output logic i);
    sdaLow = !o;
    #40 scl = 1'b1;
    #40 i = sdaLine;
    #40 scl = 1'b0;
    #40;
  endtask
  task automatic start;
    sdaLow = 1'b0;
    #40 scl = 1'b1;
    #40 sdaLow = 1'b1;
    #40 scl = 1'b0;
    #40;
  endtask
  // bus free time is spent here so callers never crowd the next frame
  task automatic stop;
    sdaLow = 1'b1;
    #40 scl = 1'b1;
    #40 sdaLow = 1'b0;
    #4700;
  endtask
  task automatic wrByte(input logic [7:0] d, output logic ack);
    logic r;
    for (int k = 7; k >= 0; k--) bitx(d[k], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  task automatic rdByte(output logic [7:0] d);
    logic r;
    for (int k = 7; k >= 0; k--) bitx(1'b1, d[k]);
    bitx(1'b1, r);
  endtask
endmodule // bus_master
`default_nettype wire

// [verification/vout_ctrl_slave_bench.sv]
// self-checking bench for the output control serial slave
`timescale 1ns/1ps
`default_nettype none
`include "vout_ctrl_defines.vh"
module vout_ctrl_slave_bench;
  logic core_clk, rst, vinOk, vccOk, enableIn, outAbove6v5, inputOvp, tempAbove160;
  logic tempBelow140, tempWarn, ocpLatch, softStartDone, sdaOut, sdaOe, mLow, a;
  logic refEnable, regulatorEnable, signalPathBlock, railPulldown, feedbackInputSelect;
  logic dynamicRegulation, absoluteOvervoltageArmed, ovLatched, thermalShutdown;
  logic errorAmpOutputPulldown;
  logic [1:0] addressSelectPin;
  logic [6:0] refCode;
  logic [7:0] outCurrent, outVoltage, ctrl1, ctrl2, d;
  logic [31:0] seed;
  logic [7:0] mdl [0:6];
  wire sclIn;
  wire sdaIn;
  int nMismatch, nChecks;
  // open-drain line: pulled up unless someone pulls it low
  assign sdaIn = !(mLow || (sdaOe && !sdaOut));
  vout_ctrl_slave #(.ID_VALUE(8'h3C)) u_vout_ctrl_slave (.core_clk, .rst, .sclIn, .sdaIn,
    .sdaOut, .sdaOe, .addressSelectPin, .vinOk, .vccOk, .enableIn, .outAbove6v5, .inputOvp,
    .tempAbove160, .tempBelow140, .tempWarn, .ocpLatch, .softStartDone, .outCurrent,
    .outVoltage, .refEnable, .regulatorEnable, .signalPathBlock, .errorAmpOutputPulldown,
    .railPulldown, .feedbackInputSelect, .refCode, .dynamicRegulation,
    .absoluteOvervoltageArmed, .ovLatched, .thermalShutdown, .ctrl1, .ctrl2);
  bus_master u_bus_master (.scl(sclIn), .sdaLow(mLow), .sdaLine(sdaIn));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = !core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    nChecks++;
    if (got !== exp) begin
      nMismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("mismatches %0d checks %0d", nMismatch, nChecks);
    if (nMismatch == 0 && nChecks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic sendAck(input logic [7:0] b);
    u_bus_master.wrByte(b, a);
    check(a, 8'h01);
  endtask
  task automatic probe(input logic [6:0] adr, input logic exp);
    u_bus_master.start;
    u_bus_master.wrByte({adr, 1'b0}, a);
    u_bus_master.stop;
    check(a, exp);
  endtask
  task automatic wrReg(input logic [7:0] r, input logic [7:0] v);
    u_bus_master.start;
    sendAck({`SLAVE_ADDR_BASE, 1'b0});
    sendAck(r);
    sendAck(v);
    u_bus_master.stop;
    mdl[r] = v;
  endtask
  task automatic rdReg(input logic [7:0] r);
    u_bus_master.start;
    sendAck({`SLAVE_ADDR_BASE, 1'b0});
    sendAck(r);
    u_bus_master.start;
    sendAck({`SLAVE_ADDR_BASE, 1'b1});
    u_bus_master.rdByte(d);
    u_bus_master.stop;
    check(d, mdl[r]);
  endtask
  initial begin
    #900000;
    nMismatch++;
    report_and_stop;
  end
  initial begin
    rst = 1'b1;
    {vinOk, vccOk, enableIn, outAbove6v5, inputOvp, tempAbove160, ocpLatch} = 7'h00;
    {tempWarn, softStartDone, tempBelow140, addressSelectPin} = 5'h04;
    seed = 32'h1401;
    {outCurrent, outVoltage} = 16'h0000;
    mdl = '{`VSEL_RESET, `CTRL1_RESET, `CTRL2_RESET, 8'h00, 8'h00, 8'h3C, 8'h00};
    tick(10);
    rst = 1'b0;
    tick(2);
    check(ctrl1, `CTRL1_RESET);
    check(ctrl2, `CTRL2_RESET);
    check({feedbackInputSelect, refCode}, {1'b1, `FIXED_REF_CODE});
    check({errorAmpOutputPulldown, railPulldown}, 8'h03);
    {vinOk, vccOk, enableIn} = 3'h7;
    for (int k = 0; k < 50 && refEnable !== 1'b1; k++) tick(1);
    check(regulatorEnable, 8'h00);
    tick(20);
    check({refEnable, regulatorEnable, railPulldown, errorAmpOutputPulldown,
      absoluteOvervoltageArmed, feedbackInputSelect}, 8'h33);
    probe(`SLAVE_ADDR_BASE, 1'b0);
    softStartDone = 1'b1;
    tick(10);
    for (int i = 0; i < 4; i++) begin
      addressSelectPin = i[1:0];
      tick(5);
      probe(`SLAVE_ADDR_BASE + 7'(2 * i), 1'b1);
      probe(`SLAVE_ADDR_BASE + 7'(2 * i + 1), 1'b0);
    end
    addressSelectPin = 2'h0;
    seed = lfsr(seed);
    {outCurrent, outVoltage, tempWarn} = {seed[15:0], 1'b1};
    mdl[3] = outCurrent;
    mdl[4] = outVoltage;
    mdl[6] = 8'h05;
    tick(5);
    for (int r = 0; r < 7; r++) rdReg(r[7:0]);
    seed = lfsr(seed);
    wrReg(`REG_CTRL2, seed[7:0]);
    check(ctrl2, mdl[2]);
    rdReg(`REG_CTRL2);
    wrReg(`REG_VSEL, 8'h1E);
    check({feedbackInputSelect, refCode}, 8'h1E);
    wrReg(`REG_CTRL1, 8'hC0);
    wrReg(`REG_VSEL, 8'h30);
    mdl[1] = 8'h80;
    check(ctrl1, mdl[1]);
    tick(1000);
    check(refCode > 7'h1E && refCode < 7'h30, 8'h01);
    for (int k = 0; k < 20000 && refCode !== 7'h30; k++) tick(1);
    check(refCode, 8'h30);
    rdReg(`REG_VSEL);
    wrReg(`REG_CTRL1, 8'h90);
    outAbove6v5 = 1'b1;
    tick(10);
    check({dynamicRegulation, ovLatched}, 8'h02);
    wrReg(`REG_CTRL1, 8'h80);
    inputOvp = 1'b1;
    tick(6);
    check({ovLatched, signalPathBlock, railPulldown, errorAmpOutputPulldown}, 8'h0C);
    tick(20);
    check({errorAmpOutputPulldown, railPulldown}, 8'h03);
    {enableIn, outAbove6v5, inputOvp} = 3'h0;
    tick(20);
    enableIn = 1'b1;
    for (int k = 0; k < 100 && regulatorEnable !== 1'b1; k++) tick(1);
    check({ovLatched, regulatorEnable}, 8'h01);
    {tempAbove160, tempBelow140} = 2'h2;
    tick(30);
    check({thermalShutdown, regulatorEnable, railPulldown}, 8'h05);
    tempAbove160 = 1'b0;
    tick(30);
    check(thermalShutdown, 8'h01);
    tempBelow140 = 1'b1;
    for (int k = 0; k < 100 && regulatorEnable !== 1'b1; k++) tick(1);
    check({thermalShutdown, regulatorEnable}, 8'h01);
    ocpLatch = 1'b1;
    tick(30);
    check({regulatorEnable, signalPathBlock, errorAmpOutputPulldown}, 8'h03);
    report_and_stop;
  end
endmodule // vout_ctrl_slave_bench
`default_nettype wire
